// >>> inc/duao_pkg.sv
`default_nettype none

package duao_pkg;

  // ==========================================================
  // Channel layout
  localparam int unsigned NUM_CH      = 8;
  localparam int unsigned CH_IDX_W    = 3;
  localparam int unsigned NARROW_LAST = 3;
  localparam int unsigned CASCADE_CH  = 4;
  localparam int unsigned WIDE_FIRST  = 5;
  localparam int unsigned WIDE_LAST   = 7;

  // ==========================================================
  // Page value layout
  localparam int unsigned PAGE_W      = 8;
  localparam int unsigned PAGE_HI_W   = 7;
  localparam int unsigned PAGE_LSB    = 0;
  localparam int unsigned PAGE_HI_LSB = 1;
  localparam int unsigned UPPER_W     = 8;
  localparam int unsigned PAGE_BUS_W  = NUM_CH * PAGE_W;

  // ==========================================================
  // Reset values
  localparam logic [PAGE_HI_W-1:0] PAGE_HI_RST = 7'h00;
  localparam logic [UPPER_W-1:0]   UPPER_RST   = 8'h00;
  localparam logic [CH_IDX_W-1:0]  CH_IDX_RST  = 3'h0;
  localparam logic                 LATCH_OFF   = 1'b1;
  localparam logic                 SEL_RST     = 1'b0;
  localparam logic                 HOLD_RST    = 1'b0;
  localparam logic                 EXTM_RST    = 1'b0;

  // ==========================================================
  // Ownership states of the high address lines
  typedef enum logic [1:0] {
    DUAO_IDLE,
    DUAO_OWN,
    DUAO_YIELD
  } duao_own_t;

endpackage

`default_nettype wire

// >>> hdl/duao_sync3.sv
`timescale 1ns/1ns
`default_nettype none

module duao_sync3 #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Asynchronous level in, filtered level out
  input  wire logic async_in,
  output var  logic level_out
);

  logic meta_ff;
  logic mid_ff;
  logic late_ff;
  logic level_ff;
  logic nxt_level;

  // Accept a change only once the second and third stages agree
  assign nxt_level = (mid_ff == late_ff) ? late_ff : level_ff;
  assign level_out = level_ff;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_ff   <= RST_VAL;
      mid_ff    <= RST_VAL;
      late_ff   <= RST_VAL;
      level_ff  <= RST_VAL;
    end
    else
    begin
      meta_ff   <= async_in;
      mid_ff    <= meta_ff;
      late_ff   <= mid_ff;
      level_ff  <= nxt_level;
    end
  end

endmodule

`default_nettype wire

// >>> hdl/duao_top.sv
`timescale 1ns/1ns
`default_nettype none

module duao_top (
  // Clock and reset
  input  wire logic                            clk,
  input  wire logic                            rstn,
  // Pins from the bus controller
  input  wire logic                            hold_grant_in,
  input  wire logic                            module_select_input,
  input  wire logic                            ext_master_in,
  // DMA core, same clock
  input  wire logic [duao_pkg::NUM_CH-1:0]     channel_grant_n,
  input  wire logic [duao_pkg::PAGE_BUS_W-1:0] page_values,
  input  wire logic                            addr_cycle_start,
  input  wire logic [duao_pkg::UPPER_W-1:0]    addr_upper_byte,
  input  wire logic                            block_mode,
  // CPU decoder, same clock
  input  wire logic                            cpu_module_req,
  // Upper address latch control
  output var  logic                            upper_addr_strobe_narrow,
  output var  logic                            upper_addr_strobe_wide,
  output var  logic                            upper_latch_enable_narrow_n,
  output var  logic                            upper_latch_enable_wide_n,
  // Page address pins
  output var  logic [duao_pkg::PAGE_HI_W-1:0]  page_high_addr_out,
  output var  logic                            page_high_addr_oe,
  output var  logic                            page_lsb_out,
  output var  logic                            page_lsb_oe,
  // Back to the DMA core and CPU decoder
  output var  logic                            s1_skip,
  output var  logic                            cpu_module_sel
);

  // ==========================================================
  // Pin synchronisers
  logic hold_sync;
  logic msel_sync;
  logic extm_sync;

  duao_sync3 #(
    .RST_VAL (duao_pkg::HOLD_RST)
  ) u_sync_hold (
    .clk       (clk),
    .rstn      (rstn),
    .async_in  (hold_grant_in),
    .level_out (hold_sync)
  );

  duao_sync3 #(
    .RST_VAL (duao_pkg::SEL_RST)
  ) u_sync_msel (
    .clk       (clk),
    .rstn      (rstn),
    .async_in  (module_select_input),
    .level_out (msel_sync)
  );

  duao_sync3 #(
    .RST_VAL (duao_pkg::EXTM_RST)
  ) u_sync_extm (
    .clk       (clk),
    .rstn      (rstn),
    .async_in  (ext_master_in),
    .level_out (extm_sync)
  );

  // ==========================================================
  // Channel decode from the active-low grants
  logic [duao_pkg::NUM_CH-1:0]   grant_act;
  logic [duao_pkg::CH_IDX_W-1:0] ch_idx;
  logic                          ch_any;
  logic                          ch_narrow;
  logic                          ch_wide;

  assign grant_act = ~channel_grant_n;

  // Lowest granted channel wins; cascade channel never selects a page
  always_comb
  begin
    ch_idx = duao_pkg::CH_IDX_RST;
    ch_any = 1'b0;
    for (int i = duao_pkg::NUM_CH - 1; i >= 0; i--)
    begin
      if (grant_act[i] && (i != duao_pkg::CASCADE_CH))
      begin
        ch_idx = i[duao_pkg::CH_IDX_W-1:0];
        ch_any = 1'b1;
      end
    end
  end

  assign ch_narrow = ch_any &&
    (ch_idx <= duao_pkg::CH_IDX_W'(duao_pkg::NARROW_LAST));
  assign ch_wide   = ch_any &&
    (ch_idx >= duao_pkg::CH_IDX_W'(duao_pkg::WIDE_FIRST)) &&
    (ch_idx <= duao_pkg::CH_IDX_W'(duao_pkg::WIDE_LAST));

  // ==========================================================
  // Bus ownership
  duao_pkg::duao_own_t own_ff;
  duao_pkg::duao_own_t nxt_own;
  logic                dma_owns;

  // Hold grant only arrives once the CPU has let go of the buses
  always_comb
  begin
    nxt_own = own_ff;
    case (own_ff)
      duao_pkg::DUAO_IDLE:
        if (hold_sync && !extm_sync)
          nxt_own = duao_pkg::DUAO_OWN;
      duao_pkg::DUAO_OWN:
        if (!hold_sync || extm_sync)
          nxt_own = duao_pkg::DUAO_YIELD;
      duao_pkg::DUAO_YIELD:
        nxt_own = duao_pkg::DUAO_IDLE;
      default:
        nxt_own = duao_pkg::DUAO_IDLE;
    endcase
  end

  assign dma_owns = (own_ff == duao_pkg::DUAO_OWN) && hold_sync && !extm_sync;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      own_ff <= duao_pkg::DUAO_IDLE;
    else
      own_ff <= nxt_own;
  end

  // ==========================================================
  // Page value selection
  logic [duao_pkg::PAGE_W-1:0] page_sel;

  assign page_sel = page_values[ch_idx*duao_pkg::PAGE_W +: duao_pkg::PAGE_W];

  logic [duao_pkg::PAGE_HI_W-1:0] nxt_page_hi;
  logic                           nxt_page_lsb;
  logic                           nxt_hi_oe;
  logic                           nxt_lsb_oe;

  assign nxt_page_hi  = dma_owns && ch_any ?
    page_sel[duao_pkg::PAGE_HI_LSB +: duao_pkg::PAGE_HI_W] :
    duao_pkg::PAGE_HI_RST;
  assign nxt_page_lsb = dma_owns && ch_narrow &&
    page_sel[duao_pkg::PAGE_LSB];
  assign nxt_hi_oe    = dma_owns && ch_any;
  assign nxt_lsb_oe   = dma_owns && ch_narrow;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      page_high_addr_out <= duao_pkg::PAGE_HI_RST;
      page_high_addr_oe  <= 1'b0;
      page_lsb_out       <= 1'b0;
      page_lsb_oe        <= 1'b0;
    end
    else
    begin
      page_high_addr_out <= nxt_page_hi;
      page_high_addr_oe  <= nxt_hi_oe;
      page_lsb_out       <= nxt_page_lsb;
      page_lsb_oe        <= nxt_lsb_oe;
    end
  end

  // ==========================================================
  // Upper latch enables
  logic nxt_len_narrow_n;
  logic nxt_len_wide_n;

  assign nxt_len_narrow_n = !(dma_owns && ch_narrow);
  assign nxt_len_wide_n   = !(dma_owns && ch_wide);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      upper_latch_enable_narrow_n <= duao_pkg::LATCH_OFF;
      upper_latch_enable_wide_n   <= duao_pkg::LATCH_OFF;
    end
    else
    begin
      upper_latch_enable_narrow_n <= nxt_len_narrow_n;
      upper_latch_enable_wide_n   <= nxt_len_wide_n;
    end
  end

  // ==========================================================
  // Upper address strobes
  logic [duao_pkg::UPPER_W-1:0] last_narrow_ff;
  logic [duao_pkg::UPPER_W-1:0] last_wide_ff;
  logic                         narrow_valid_ff;
  logic                         wide_valid_ff;
  logic                         need_narrow;
  logic                         need_wide;
  logic                         take_narrow;
  logic                         take_wide;
  logic                         nxt_stb_narrow;
  logic                         nxt_stb_wide;
  logic                         nxt_skip;

  // Block mode only re-latches when the byte differs or no byte is remembered
  assign need_narrow = !block_mode || !narrow_valid_ff ||
    (addr_upper_byte != last_narrow_ff);
  assign need_wide   = !block_mode || !wide_valid_ff ||
    (addr_upper_byte != last_wide_ff);

  assign take_narrow = addr_cycle_start && dma_owns && ch_narrow;
  assign take_wide   = addr_cycle_start && dma_owns && ch_wide;

  assign nxt_stb_narrow = take_narrow && need_narrow;
  assign nxt_stb_wide   = take_wide && need_wide;
  assign nxt_skip       = (take_narrow && !need_narrow) ||
                          (take_wide && !need_wide);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      upper_addr_strobe_narrow <= 1'b0;
      upper_addr_strobe_wide   <= 1'b0;
      s1_skip                  <= 1'b0;
    end
    else
    begin
      upper_addr_strobe_narrow <= nxt_stb_narrow;
      upper_addr_strobe_wide   <= nxt_stb_wide;
      s1_skip                  <= nxt_skip;
    end
  end

  // Remembered bytes forget once the bus is given back
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      last_narrow_ff  <= duao_pkg::UPPER_RST;
      narrow_valid_ff <= 1'b0;
    end
    else if (!dma_owns)
      narrow_valid_ff <= 1'b0;
    else if (nxt_stb_narrow)
    begin
      last_narrow_ff  <= addr_upper_byte;
      narrow_valid_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      last_wide_ff  <= duao_pkg::UPPER_RST;
      wide_valid_ff <= 1'b0;
    end
    else if (!dma_owns)
      wide_valid_ff <= 1'b0;
    else if (nxt_stb_wide)
    begin
      last_wide_ff  <= addr_upper_byte;
      wide_valid_ff <= 1'b1;
    end
  end

  // ==========================================================
  // CPU module select gating
  logic nxt_cpu_sel;

  // Low select isolates CPU access only; DMA paths above ignore it
  assign nxt_cpu_sel = cpu_module_req && msel_sync;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      cpu_module_sel <= 1'b0;
    else
      cpu_module_sel <= nxt_cpu_sel;
  end

endmodule

`default_nettype wire

// >>> verif/duao_chk.sv
`timescale 1ns/1ns
`default_nettype none
module duao_chk (
  // Inputs
  input wire logic                        clk,
  input wire logic                        rstn,
  input wire logic                        hold_grant_in,
  input wire logic                        module_select_input,
  input wire logic                        ext_master_in,
  input wire logic [duao_pkg::NUM_CH-1:0] channel_grant_n,
  input wire logic                        addr_cycle_start,
  input wire logic                        cpu_module_req,
  // Outputs
  input wire logic                        upper_addr_strobe_narrow,
  input wire logic                        upper_addr_strobe_wide,
  input wire logic                        upper_latch_enable_narrow_n,
  input wire logic                        upper_latch_enable_wide_n,
  input wire logic                        page_high_addr_oe,
  input wire logic                        page_lsb_oe,
  input wire logic                        s1_skip,
  input wire logic                        cpu_module_sel
);
  // =========
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_narrow_strobe: assert property (
    upper_addr_strobe_narrow |-> $past(addr_cycle_start)
      && !upper_latch_enable_narrow_n) else $error("bad narrow strobe");
  chk_wide_strobe: assert property (
    upper_addr_strobe_wide |-> $past(addr_cycle_start)
      && !upper_latch_enable_wide_n) else $error("bad wide strobe");
  chk_skip_no_strobe: assert property (
    s1_skip |-> $past(addr_cycle_start) && !upper_addr_strobe_narrow
      && !upper_addr_strobe_wide) else $error("strobe with skip");
  chk_narrow_chan: assert property (
    !upper_latch_enable_narrow_n |-> $past(channel_grant_n[3:0]) != 4'hF)
    else $error("narrow enable without channel");
  chk_wide_chan: assert property (
    !upper_latch_enable_wide_n |-> $past(channel_grant_n[3:0]) == 4'hF
      && $past(channel_grant_n[7:5]) != 3'h7) else $error("bad wide enable");
  chk_ext_master_off: assert property (
    ext_master_in [*7] |-> upper_latch_enable_narrow_n
      && upper_latch_enable_wide_n) else $error("enable under master");
  chk_cpu_sel_on: assert property (
    (module_select_input && cpu_module_req) [*7] |-> cpu_module_sel)
    else $error("cpu select missing");
  chk_cpu_sel_off: assert property (
    !module_select_input [*7] |-> !cpu_module_sel)
    else $error("cpu select while isolated");
  chk_float_no_hold: assert property (
    !hold_grant_in [*6] |-> !page_high_addr_oe && !page_lsb_oe)
    else $error("pins driven without hold");
  chk_lsb_narrow: assert property (
    page_lsb_oe |-> !upper_latch_enable_narrow_n && upper_latch_enable_wide_n)
    else $error("page lsb on wide cycle");
  cov_narrow: cover property (upper_addr_strobe_narrow);
  cov_wide: cover property (upper_addr_strobe_wide);
  cov_skip: cover property (s1_skip);
endmodule
bind duao_top duao_chk i_chk (
  .clk                         (clk),
  .rstn                        (rstn),
  .hold_grant_in               (hold_grant_in),
  .module_select_input         (module_select_input),
  .ext_master_in               (ext_master_in),
  .channel_grant_n             (channel_grant_n),
  .addr_cycle_start            (addr_cycle_start),
  .cpu_module_req              (cpu_module_req),
  .upper_addr_strobe_narrow    (upper_addr_strobe_narrow),
  .upper_addr_strobe_wide      (upper_addr_strobe_wide),
  .upper_latch_enable_narrow_n (upper_latch_enable_narrow_n),
  .upper_latch_enable_wide_n   (upper_latch_enable_wide_n),
  .page_high_addr_oe           (page_high_addr_oe),
  .page_lsb_oe                 (page_lsb_oe),
  .s1_skip                     (s1_skip),
  .cpu_module_sel              (cpu_module_sel)
);
`default_nettype wire

// >>> verif/duao_bus_ctl_mdl.sv
`timescale 1ns/1ns
`default_nettype none
module duao_bus_ctl_mdl #(
  parameter int REL_CYC = 3
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Hold handshake
  input  wire logic hold_req,
  output var  logic hold_grant_in
);
  logic [3:0] rel_cnt_ff;
  // =========
  // Grant once the CPU has let go of the buses
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rel_cnt_ff    <= 4'h0;
      hold_grant_in <= 1'b0;
    end
    else if (!hold_req)
    begin
      rel_cnt_ff    <= 4'h0;
      hold_grant_in <= 1'b0;
    end
    else if (rel_cnt_ff == REL_CYC[3:0])
      hold_grant_in <= 1'b1;
    else
      rel_cnt_ff <= rel_cnt_ff + 4'h1;
  end
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        hold_req = 1'b0;
  logic        hold_grant_in;
  logic        module_select_input = 1'b0;
  logic        ext_master_in = 1'b0;
  logic [7:0]  channel_grant_n = 8'hFF;
  logic [63:0] page_values = 64'hF7E6D5C4B3A29180;
  logic        addr_cycle_start = 1'b0;
  logic [7:0]  addr_upper_byte = 8'h00;
  logic        block_mode = 1'b0;
  logic        cpu_module_req = 1'b0;
  logic        upper_addr_strobe_narrow;
  logic        upper_addr_strobe_wide;
  logic        upper_latch_enable_narrow_n;
  logic        upper_latch_enable_wide_n;
  logic [6:0]  page_high_addr_out;
  logic        page_high_addr_oe;
  logic        page_lsb_out;
  logic        page_lsb_oe;
  logic        s1_skip;
  logic        cpu_module_sel;
  logic [15:0] st;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          cyc = 0;
  assign st = {page_high_addr_out, s1_skip, cpu_module_sel, page_high_addr_oe,
               page_lsb_oe, page_lsb_out, upper_addr_strobe_narrow,
               upper_addr_strobe_wide, upper_latch_enable_narrow_n,
               upper_latch_enable_wide_n};
  duao_top i_dut (
    .clk                         (clk),
    .rstn                        (rstn),
    .hold_grant_in               (hold_grant_in),
    .module_select_input         (module_select_input),
    .ext_master_in               (ext_master_in),
    .channel_grant_n             (channel_grant_n),
    .page_values                 (page_values),
    .addr_cycle_start            (addr_cycle_start),
    .addr_upper_byte             (addr_upper_byte),
    .block_mode                  (block_mode),
    .cpu_module_req              (cpu_module_req),
    .upper_addr_strobe_narrow    (upper_addr_strobe_narrow),
    .upper_addr_strobe_wide      (upper_addr_strobe_wide),
    .upper_latch_enable_narrow_n (upper_latch_enable_narrow_n),
    .upper_latch_enable_wide_n   (upper_latch_enable_wide_n),
    .page_high_addr_out          (page_high_addr_out),
    .page_high_addr_oe           (page_high_addr_oe),
    .page_lsb_out                (page_lsb_out),
    .page_lsb_oe                 (page_lsb_oe),
    .s1_skip                     (s1_skip),
    .cpu_module_sel              (cpu_module_sel)
  );
  duao_bus_ctl_mdl i_bus (
    .clk           (clk),
    .rstn          (rstn),
    .hold_req      (hold_req),
    .hold_grant_in (hold_grant_in)
  );
  always #2 clk = ~clk;
  // =========
  // Helpers
  task automatic finish_test;
    if (error_cnt == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      error_cnt++;
      finish_test;
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic start(input logic [7:0] ub, input logic blk);
    addr_cycle_start = 1'b1;
    addr_upper_byte  = ub;
    block_mode       = blk;
    tick(1);
    addr_cycle_start = 1'b0;
  endtask
  // =========
  // Scenarios
  task automatic t_cpu;
    module_select_input = 1'b1;
    cpu_module_req      = 1'b1;
    tick(7);
    check({15'h0, st[7]}, 16'h1);
    module_select_input = 1'b0;
    tick(7);
    check({15'h0, st[7]}, 16'h0);
    cpu_module_req = 1'b0;
  endtask
  task automatic t_narrow;
    channel_grant_n = 8'hFD;
    hold_req        = 1'b1;
    tick(12);
    check(st, 16'h9071);
    start(8'h12, 1'b1);
    check(st, 16'h9079);
    tick(1);
    start(8'h12, 1'b1);
    check(st, 16'h9171);
    tick(1);
    start(8'h13, 1'b1);
    check(st, 16'h9079);
    tick(1);
    start(8'h13, 1'b0);
    check(st, 16'h9079);
  endtask
  task automatic t_wide;
    channel_grant_n = 8'hBF;
    tick(2);
    check(st, 16'hE642);
    start(8'h13, 1'b1);
    check(st, 16'hE646);
    tick(1);
    start(8'h13, 1'b1);
    check(st, 16'hE742);
    channel_grant_n = 8'hEF;
    tick(2);
    check({14'h0, st[1:0]}, 16'h3);
  endtask
  task automatic t_chan;
    channel_grant_n = 8'h7B;
    tick(2);
    check(st, 16'hA261);
    channel_grant_n = 8'h77;
    tick(2);
    check(st, 16'hB271);
    channel_grant_n = 8'h5F;
    tick(2);
    check(st, 16'hD442);
    channel_grant_n = 8'h7F;
    tick(2);
    check(st, 16'hF642);
  endtask
  task automatic t_master_release;
    channel_grant_n = 8'hFE;
    ext_master_in   = 1'b1;
    tick(8);
    check({14'h0, st[1:0]}, 16'h3);
    ext_master_in = 1'b0;
    hold_req      = 1'b0;
    tick(8);
    check({14'h0, st[6:5]}, 16'h0);
  endtask
  initial
  begin
    tick(10);
    rstn = 1'b1;
    tick(1);
    check(st, 16'h0003);
    t_cpu;
    t_narrow;
    t_wide;
    t_chan;
    t_master_release;
    finish_test;
  end
endmodule
`default_nettype wire
